//--- src/uafr_pkg.sv
/*
  Shared constants, types and decode helpers of the serial port block.
  Assumes a single 25 MHz core clock and an AHB-Lite register bus.
*/
// Contract
// - Frame out: start, data LSB first, optional parity, stop bits.
// - Five to eight data bits, both directions.
// - Parity even, odd, stick or none, same for send and check.
// - One or two stop bits as programmed.
// - Receive after valid start; flag overrun, parity, framing, break.
// - Divisor is 16-bit integer plus 6-bit fraction, two registers.
// - Divisor equals clock over sixteen times baud, fraction in 64ths.
// - Oversample tick at sixteen times baud; bit clock is tick over 16.
// - Divisors and line control held in one 30-bit latch on line write.
// - Transmit and receive enables reset enabled.
// - Clearing global enable lets the current character finish.
// - Separate transmit and receive queues, sixteen by eight and sixteen by twelve; the receive entries carry four status bits.
// - Queue depth programmable, one-entry mode as holding register.
// - Trigger levels one-eighth to seven-eighths full.
// - Transmitter sends break on plain pins only, receiver detects break.
// - Baud generator programmable up to 1.5625 Mbit/s.
// - Setting selects infrared encoded or plain serial pins.
// - Infrared pulse 3/16 bit, or low-power width from divided clock.
// - Low-power clock divides reference by 1 to 256.
// - Separate DMA requests for transmit and receive.
// - Start checked on eighth tick; bits sampled every sixteenth.
// - Stop bit sampled low gives framing error.
// - Busy from queue non-empty until last stop bit leaves.
// - After reset queues are disabled, one entry deep.
package uafr_pkg;
  // Register byte offsets
  localparam logic [7:0] ADDR_DATA = 8'h00;
  localparam logic [7:0] ADDR_FLAG = 8'h04;
  localparam logic [7:0] ADDR_RXST = 8'h08;
  localparam logic [7:0] ADDR_IDIV = 8'h0c;
  localparam logic [7:0] ADDR_FDIV = 8'h10;
  localparam logic [7:0] ADDR_LINE = 8'h14;
  localparam logic [7:0] ADDR_CTRL = 8'h18;
  localparam logic [7:0] ADDR_LVL = 8'h1c;
  localparam logic [7:0] ADDR_LPDIV = 8'h20;
  localparam logic [7:0] ADDR_DMA = 8'h24;
  // Line control fields
  localparam int LC_BRK = 0;
  localparam int LC_PEN = 1;
  localparam int LC_EPS = 2;
  localparam int LC_STP2 = 3;
  localparam int LC_FEN = 4;
  localparam int LC_WLEN = 5;
  localparam int LC_SPS = 7;
  // Port control fields and reset
  localparam int CT_EN = 0;
  localparam int CT_SIR = 1;
  localparam int CT_SIRLP = 2;
  localparam int CT_TXE = 8;
  localparam int CT_RXE = 9;
  localparam logic [9:0] CTRL_RST = 10'h300;
  localparam logic [5:0] LVL_RST = 6'h12;
  // Latched 30-bit configuration layout
  localparam int CF_IDIV = 14;
  localparam int CF_FDIV = 8;
  // Receive entry status bits
  localparam int E_FE = 8;
  localparam int E_PE = 9;
  localparam int E_BE = 10;
  localparam int E_OE = 11;
  // Oversampling counts
  localparam logic [3:0] SUB_LAST = 4'hf;
  localparam logic [3:0] START_CHK = 4'h7;
  localparam logic [3:0] SIR_WIDTH = 4'h3;
  localparam logic [1:0] LP_WIDTH = 2'h3;
  localparam logic [4:0] SIR_HOLD = 5'h10;
  localparam logic [2:0] WLEN_BASE = 3'h4;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_START = 3'b001,
    ST_DATA = 3'b011,
    ST_PAR = 3'b010,
    ST_STOP = 3'b110
  } uafr_state_t;

  // Trigger level select to entry count of a sixteen-deep queue
  function automatic logic [4:0] uafr_level(input logic [2:0] sel);
    case (sel)
      3'h0: uafr_level = 5'h02;
      3'h1: uafr_level = 5'h04;
      3'h3: uafr_level = 5'h0c;
      3'h4: uafr_level = 5'h0e;
      default: uafr_level = 5'h08;
    endcase
  endfunction

  // Parity bit for the active data width and mode
  function automatic logic uafr_parity(input logic [7:0] d,
      input logic [1:0] wlen, input logic eps, input logic sps);
    logic [7:0] m;
    m = 8'hff >> (2'h3 - wlen);
    if (sps) begin
      uafr_parity = ~eps;
    end else begin
      uafr_parity = (^(d & m)) ^ ~eps;
    end
  endfunction
endpackage

//--- src/uafr_fifo_if.sv
/*
  Queue port bundle between the port core and its storage.
  Assumes the owner drives push, pop and depth mode in one clock domain.
*/
`timescale 1ns/10ps
interface uafr_fifo_if #(parameter int W = 8, parameter int DEPTH = 16);
  logic push;
  logic [W-1:0] wdata;
  logic pop;
  logic [W-1:0] rdata;
  logic [$clog2(DEPTH):0] count;
  logic full;
  logic empty;
  logic one_deep;
  modport owner(output push, wdata, pop, one_deep,
    input rdata, count, full, empty);
  modport store(input push, wdata, pop, one_deep,
    output rdata, count, full, empty);
endinterface

//--- src/uafr_fifo.sv
/*
  Flip-flop queue, index addressed, with a one-entry holding mode.
  Ignores a push when full and a pop when empty; the owner may issue either.
*/
`timescale 1ns/10ps
module uafr_fifo #(parameter int W = 8, parameter int DEPTH = 16) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Queue port
  uafr_fifo_if.store q
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_idx;
  logic [AW-1:0] rd_idx;
  logic [AW:0] cnt;
  logic do_push;
  logic do_pop;

  // One-entry mode caps the count so it acts as a holding register
  assign q.full = q.one_deep ? (cnt != '0) : (cnt == (AW+1)'(DEPTH));
  assign q.empty = (cnt == '0);
  assign q.count = cnt;
  assign q.rdata = mem[rd_idx];
  assign do_push = q.push && !q.full;
  assign do_pop = q.pop && !q.empty;

  // Storage has no reset; only valid entries are ever read
  always_ff @(posedge core_clk) begin
    if (do_push) begin
      mem[wr_idx] <= q.wdata;
    end
  end

  // Indices and fill count
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      wr_idx <= '0;
      rd_idx <= '0;
      cnt <= '0;
    end else begin
      if (do_push) begin
        wr_idx <= wr_idx + 1'b1;
      end
      if (do_pop) begin
        rd_idx <= rd_idx + 1'b1;
      end
      cnt <= cnt + (AW+1)'(do_push) - (AW+1)'(do_pop);
    end
  end
endmodule

//--- src/uafr_top.sv
/*
  Serial port core: AHB-Lite registers, fractional baud generator,
  framer, deframer, infrared coder and DMA requests.
  Assumes synchronous serial input and a single-slave AHB-Lite bus.
*/
`timescale 1ns/10ps
module uafr_top import uafr_pkg::*; #(
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Serial pins
  input wire logic serial_receive_pin,
  output logic serial_transmit_pin,
  // DMA requests
  output logic tx_dma_req,
  output logic rx_dma_req
);
  uafr_fifo_if #(.W(8), .DEPTH(DEPTH)) txq();
  uafr_fifo_if #(.W(12), .DEPTH(DEPTH)) rxq();

  uafr_fifo #(.W(8), .DEPTH(DEPTH)) u_txq (
    .core_clk(core_clk),
    .rstn(rstn),
    .q(txq.store)
  );
  uafr_fifo #(.W(12), .DEPTH(DEPTH)) u_rxq (
    .core_clk(core_clk),
    .rstn(rstn),
    .q(rxq.store)
  );

  // Software-visible registers
  logic [15:0] integer_divisor_register;
  logic [5:0] fraction_divisor_register;
  logic [29:0] cfg;
  logic [9:0] port_control_register;
  logic [5:0] level_select;
  logic [7:0] lp_divisor;
  logic [1:0] dma_enable;
  logic rx_overrun;
  // Bus pipeline
  logic wr_pend;
  logic [7:0] wr_addr;
  logic ap_valid;
  logic [7:0] ap_addr;
  // Decoded configuration
  logic [7:0] line_control_register;
  logic [15:0] divisor_integer_part;
  logic [5:0] divisor_fraction_part;
  logic global_port_enable;
  logic transmit_enable_bit;
  logic receive_enable_bit;
  logic fifo_enable_bit;
  logic sir_on;
  logic [2:0] last_bit;
  // Baud generator
  logic [15:0] baud_cnt;
  logic [5:0] frac_acc;
  logic extra;
  logic oversample_tick;
  logic [6:0] frac_sum;
  // Transmitter
  uafr_state_t tx_state;
  logic [3:0] tx_sub;
  logic [2:0] tx_bitn;
  logic [7:0] tx_shift;
  logic tx_par;
  logic tx_stop2;
  logic tx_go;
  logic tx_line;
  logic busy;
  // Low-power infrared clock
  logic [7:0] lp_cnt;
  logic lp_tick;
  logic [1:0] lp_left;
  logic tx_bit_begin;
  logic sir_pulse;
  // Receiver
  uafr_state_t rx_state;
  logic [3:0] rx_sub;
  logic [2:0] rx_bitn;
  logic [7:0] rx_shift;
  logic rx_q;
  logic [4:0] sir_hold;
  logic rx_bit;
  logic rx_armed;
  logic rx_any_one;
  logic rx_perr;
  logic rx_push;
  logic oe_pending;

  assign line_control_register = cfg[CF_FDIV-1:0];
  assign divisor_fraction_part = cfg[CF_IDIV-1:CF_FDIV];
  assign divisor_integer_part = cfg[29:CF_IDIV];
  assign global_port_enable = port_control_register[CT_EN];
  assign transmit_enable_bit = port_control_register[CT_TXE];
  assign receive_enable_bit = port_control_register[CT_RXE];
  assign sir_on = port_control_register[CT_SIR];
  assign fifo_enable_bit = line_control_register[LC_FEN];
  assign last_bit = {1'b0, line_control_register[LC_WLEN+:2]} + WLEN_BASE;
  assign ap_valid = hsel && htrans[1] && hready;
  assign ap_addr = haddr[7:0];

  // Queue depth follows the latched enable; off means one entry
  assign txq.one_deep = !fifo_enable_bit;
  assign rxq.one_deep = !fifo_enable_bit;
  assign txq.push = wr_pend && (wr_addr == ADDR_DATA);
  assign txq.wdata = hwdata[7:0];
  assign rxq.pop = ap_valid && !hwrite && (ap_addr == ADDR_DATA);

  // Data phase: writes land one cycle after their address
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      wr_pend <= ap_valid && hwrite;
      wr_addr <= ap_addr;
      hreadyout <= 1'b1; // Zero wait states, always OKAY
      hresp <= 1'b0;
    end
  end

  // Register writes; the divisor latch loads only on a line write
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      integer_divisor_register <= 16'h0000;
      fraction_divisor_register <= 6'h00;
      cfg <= 30'h00000000;
      port_control_register <= CTRL_RST;
      level_select <= LVL_RST;
      lp_divisor <= 8'h00;
      dma_enable <= 2'h0;
    end else if (wr_pend) begin
      case (wr_addr)
        ADDR_IDIV: integer_divisor_register <= hwdata[15:0];
        ADDR_FDIV: fraction_divisor_register <= hwdata[5:0];
        ADDR_LINE: cfg <= {integer_divisor_register,
          fraction_divisor_register, hwdata[7:0]};
        ADDR_CTRL: port_control_register <= hwdata[9:0];
        ADDR_LVL: level_select <= hwdata[5:0];
        ADDR_LPDIV: lp_divisor <= hwdata[7:0];
        ADDR_DMA: dma_enable <= hwdata[1:0];
        default: ;
      endcase
    end
  end

  // Read data is registered in the address phase, so it stands in
  // the data phase; a read right after a write sees the old value
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      hrdata <= 32'h00000000;
    end else if (ap_valid && !hwrite) begin
      case (ap_addr)
        ADDR_DATA: hrdata <= {20'h00000, rxq.rdata};
        ADDR_FLAG: hrdata <= {25'h0000000,
          rxq.count >= uafr_level(level_select[5:3]),
          txq.count <= uafr_level(level_select[2:0]),
          busy, txq.empty, rxq.full, txq.full, rxq.empty};
        ADDR_RXST: hrdata <= {31'h00000000, rx_overrun};
        ADDR_IDIV: hrdata <= {16'h0000, integer_divisor_register};
        ADDR_FDIV: hrdata <= {26'h0000000, fraction_divisor_register};
        ADDR_LINE: hrdata <= {24'h000000, line_control_register};
        ADDR_CTRL: hrdata <= {22'h000000, port_control_register};
        ADDR_LVL: hrdata <= {26'h0000000, level_select};
        ADDR_LPDIV: hrdata <= {24'h000000, lp_divisor};
        ADDR_DMA: hrdata <= {30'h00000000, dma_enable};
        default: hrdata <= 32'h00000000;
      endcase
    end
  end

  // Fractional divider: integer count, one extra clock on carry
  assign frac_sum = {1'b0, frac_acc} + {1'b0, divisor_fraction_part};
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      baud_cnt <= 16'h0000;
      frac_acc <= 6'h00;
      extra <= 1'b0;
      oversample_tick <= 1'b0;
    end else if (divisor_integer_part == 16'h0000) begin
      baud_cnt <= 16'h0000;
      oversample_tick <= 1'b0;
    end else if ({1'b0, baud_cnt} + 17'h1 >=
        {1'b0, divisor_integer_part} + {16'h0, extra}) begin
      baud_cnt <= 16'h0000;
      frac_acc <= frac_sum[5:0];
      extra <= frac_sum[6];
      oversample_tick <= 1'b1;
    end else begin
      baud_cnt <= baud_cnt + 16'h1;
      oversample_tick <= 1'b0;
    end
  end

  // A new character starts only while enabled; once started it ends
  assign tx_go = global_port_enable && transmit_enable_bit
    && !txq.empty;
  assign txq.pop = oversample_tick && (tx_state == ST_IDLE) && tx_go;
  assign busy = !txq.empty || (tx_state != ST_IDLE);

  // Framer: sixteen ticks per bit
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      tx_state <= ST_IDLE;
      tx_sub <= 4'h0;
      tx_bitn <= 3'h0;
      tx_shift <= 8'h00;
      tx_par <= 1'b0;
      tx_stop2 <= 1'b0;
    end else if (oversample_tick) begin
      tx_sub <= (tx_state == ST_IDLE) ? 4'h0 : tx_sub + 4'h1;
      case (tx_state)
        ST_IDLE: if (tx_go) begin
          tx_state <= ST_START;
          tx_shift <= txq.rdata;
          tx_par <= uafr_parity(txq.rdata,
            line_control_register[LC_WLEN+:2],
            line_control_register[LC_EPS],
            line_control_register[LC_SPS]);
          tx_stop2 <= 1'b0;
        end
        ST_START: if (tx_sub == SUB_LAST) begin
          tx_state <= ST_DATA;
          tx_bitn <= 3'h0;
        end
        ST_DATA: if (tx_sub == SUB_LAST) begin
          tx_shift <= tx_shift >> 1;
          tx_bitn <= tx_bitn + 3'h1;
          if (tx_bitn == last_bit) begin
            tx_state <= line_control_register[LC_PEN] ?
              ST_PAR : ST_STOP;
          end
        end
        ST_PAR: if (tx_sub == SUB_LAST) begin
          tx_state <= ST_STOP;
        end
        ST_STOP: if (tx_sub == SUB_LAST) begin
          if (line_control_register[LC_STP2] && !tx_stop2) begin
            tx_stop2 <= 1'b1;
          end else begin
            tx_state <= ST_IDLE;
          end
        end
        default: tx_state <= ST_IDLE;
      endcase
    end
  end

  // Line level of the bit being sent
  always_comb begin
    case (tx_state)
      ST_START: tx_line = 1'b0;
      ST_DATA: tx_line = tx_shift[0];
      ST_PAR: tx_line = tx_par;
      default: tx_line = 1'b1;
    endcase
  end

  // Low-power clock: divide by lp_divisor plus one, 1 to 256
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      lp_cnt <= 8'h00;
      lp_tick <= 1'b0;
    end else if (lp_cnt >= lp_divisor) begin
      lp_cnt <= 8'h00;
      lp_tick <= 1'b1;
    end else begin
      lp_cnt <= lp_cnt + 8'h1;
      lp_tick <= 1'b0;
    end
  end

  // Infrared pulse timer rearmed at every bit boundary
  assign tx_bit_begin = oversample_tick && ((tx_sub == SUB_LAST)
    || (tx_state == ST_IDLE && tx_go));
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      lp_left <= 2'h0;
    end else if (tx_bit_begin) begin
      lp_left <= LP_WIDTH;
    end else if (lp_tick && lp_left != 2'h0) begin
      lp_left <= lp_left - 2'h1;
    end
  end
  assign sir_pulse = port_control_register[CT_SIRLP] ?
    (lp_left != 2'h0) : (tx_sub < SIR_WIDTH);

  // Pin: infrared sends a high pulse per zero, plain idles high
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      serial_transmit_pin <= 1'b1;
    end else if (sir_on) begin
      serial_transmit_pin <= (tx_state != ST_IDLE) && !tx_line
        && sir_pulse;
    end else begin
      serial_transmit_pin <= tx_line
        && !line_control_register[LC_BRK];
    end
  end

  // Receive decode: an infrared low pulse stands for a whole zero bit
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rx_q <= 1'b1;
      sir_hold <= 5'h00;
    end else begin
      rx_q <= serial_receive_pin;
      if (!rx_q) begin
        sir_hold <= SIR_HOLD;
      end else if (oversample_tick && sir_hold != 5'h00) begin
        sir_hold <= sir_hold - 5'h1;
      end
    end
  end
  assign rx_bit = sir_on ? (rx_q && sir_hold == 5'h00) : rx_q;

  // Deframer
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rx_state <= ST_IDLE;
      rx_sub <= 4'h0;
      rx_bitn <= 3'h0;
      rx_shift <= 8'h00;
      rx_armed <= 1'b0;
      rx_any_one <= 1'b0;
      rx_perr <= 1'b0;
    end else if (oversample_tick) begin
      rx_sub <= rx_sub + 4'h1;
      case (rx_state)
        ST_IDLE: begin
          rx_sub <= 4'h0;
          rx_armed <= rx_bit; // Rearm only after the line is high
          if (rx_armed && !rx_bit && global_port_enable
              && receive_enable_bit) begin
            rx_state <= ST_START;
            rx_shift <= 8'h00;
            rx_any_one <= 1'b0;
            rx_perr <= 1'b0;
          end
        end
        ST_START: if (rx_sub == START_CHK) begin
          rx_sub <= 4'h0;
          rx_bitn <= 3'h0;
          rx_state <= rx_bit ? ST_IDLE : ST_DATA;
        end
        ST_DATA: if (rx_sub == SUB_LAST) begin
          rx_shift[rx_bitn] <= rx_bit;
          rx_any_one <= rx_any_one | rx_bit;
          rx_bitn <= rx_bitn + 3'h1;
          if (rx_bitn == last_bit) begin
            rx_state <= line_control_register[LC_PEN] ?
              ST_PAR : ST_STOP;
          end
        end
        ST_PAR: if (rx_sub == SUB_LAST) begin
          rx_any_one <= rx_any_one | rx_bit;
          rx_perr <= rx_bit != uafr_parity(rx_shift,
            line_control_register[LC_WLEN+:2],
            line_control_register[LC_EPS],
            line_control_register[LC_SPS]);
          rx_state <= ST_STOP;
        end
        ST_STOP: if (rx_sub == SUB_LAST) begin
          rx_state <= ST_IDLE;
          rx_armed <= 1'b0;
        end
        default: rx_state <= ST_IDLE;
      endcase
    end
  end

  // Store the character with its status at the stop sample
  assign rx_push = oversample_tick && (rx_state == ST_STOP)
    && (rx_sub == SUB_LAST);
  assign rxq.push = rx_push;
  assign rxq.wdata = {oe_pending, !rx_any_one && !rx_bit,
    rx_perr, !rx_bit, rx_shift};

  // Overrun: a character lost to a full queue; set wins over clear
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rx_overrun <= 1'b0;
      oe_pending <= 1'b0;
    end else begin
      if (rx_push && rxq.full) begin
        rx_overrun <= 1'b1;
        oe_pending <= 1'b1;
      end else begin
        if (wr_pend && wr_addr == ADDR_RXST) begin
          rx_overrun <= 1'b0;
        end
        if (rx_push) begin
          oe_pending <= 1'b0;
        end
      end
    end
  end

  // DMA requests: room to send, data to fetch
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      tx_dma_req <= 1'b0;
      rx_dma_req <= 1'b0;
    end else begin
      tx_dma_req <= dma_enable[0] && !txq.full;
      rx_dma_req <= dma_enable[1] && !rxq.empty;
    end
  end
endmodule

//--- tb/uafr_remote.sv
/* Remote serial port model: decodes frames, sends frames on command.
   Assumes no parity, one stop bit seen, bit length fixed in clocks. */
`timescale 1ns/10ps
module uafr_remote #(parameter int BIT = 32) (
  // Clock
  input wire logic core_clk,
  // Serial lines
  input wire logic line_in,
  output logic line_out,
  // Decoded characters
  input wire logic [3:0] nbits,
  output logic got,
  output logic [7:0] got_data
);
  initial begin
    line_out = 1'b1;
    got = 1'b0;
    got_data = 8'h00;
  end
  // Receiver samples mid-bit; a low stop bit gives no character
  initial forever begin
    @(negedge line_in);
    repeat (BIT / 2) @(posedge core_clk);
    if (!line_in) begin
      got_data = 8'h00;
      for (int i = 0; i < nbits; i++) begin
        repeat (BIT) @(posedge core_clk);
        got_data[i] = line_in;
      end
      repeat (BIT) @(posedge core_clk);
      got <= line_in;
      @(posedge core_clk);
      got <= 1'b0;
    end
  end
  // Eight data bits LSB first; stop low forces a framing fault
  task automatic send_char(input logic [7:0] d, input logic stop);
    line_out <= 1'b0;
    repeat (BIT) @(posedge core_clk);
    for (int i = 0; i < 8; i++) begin
      line_out <= d[i];
      repeat (BIT) @(posedge core_clk);
    end
    line_out <= stop;
    repeat (BIT) @(posedge core_clk);
    line_out <= 1'b1; // Idle high before the next start
    repeat (BIT) @(posedge core_clk);
  endtask
endmodule

//--- tb/uafr_top_properties.sv
/* Concurrent checks on the serial port's top-level pins.
   Assumes binding to uafr_top, one core clock domain. */
`timescale 1ns/10ps
module uafr_top_properties (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // Pins
  input wire logic serial_transmit_pin,
  input wire logic tx_dma_req,
  input wire logic rx_dma_req
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  logic rd_ph;
  // Read address phase taken
  assign rd_ph = hsel && htrans[1] && hready && !hwrite;
  a_ready_high: assert property (hreadyout)
    else $error("slave inserted a wait state");
  a_resp_okay: assert property (!hresp)
    else $error("slave gave an error response");
  a_unmapped_zero: assert property (rd_ph && haddr[7:0] > 8'h24
    |=> hrdata == 32'h0) else $error("unmapped read not zero");
  a_rdata_hold: assert property (!$past(rd_ph) |-> $stable(hrdata))
    else $error("read data moved without a read");
  // Bits last sixteen ticks of at least one clock each
  a_low_bit: assert property ($fell(serial_transmit_pin) |->
    !serial_transmit_pin [*8]) else $error("low bit too short");
  a_high_bit: assert property ($rose(serial_transmit_pin) |->
    serial_transmit_pin [*8]) else $error("high bit too short");
  a_idle_release: assert property ($rose(rstn) |->
    serial_transmit_pin [*2]) else $error("line not idle high");
  a_dma_quiet: assert property ($rose(rstn) |->
    (!tx_dma_req && !rx_dma_req) [*2]) else $error("dma request at reset");
  c_tx_frame: cover property ($fell(serial_transmit_pin));
  c_rx_dma: cover property ($rose(rx_dma_req));
  c_unmapped: cover property (rd_ph && haddr[7:0] == 8'h28);
endmodule

//--- tb/uafr_top_bench.sv
/* Self-checking bench of the serial port core with a remote port model.
   Assumes single AHB-Lite transfers and a 25 MHz core clock. */
`timescale 1ns/10ps
bind uafr_top uafr_top_properties u_props (.core_clk, .rstn, .hsel,
  .haddr, .htrans, .hwrite, .hready, .hrdata, .hreadyout, .hresp,
  .serial_transmit_pin, .tx_dma_req, .rx_dma_req);
module uafr_top_bench import uafr_pkg::*;;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout, hresp, tx_line, rx_line, tx_dma_req, rx_dma_req, got;
  logic dph = 1'b0;
  logic [7:0] got_data;
  logic [3:0] nb = 4'h8;
  logic [31:0] rnd = 32'h2195;
  logic [31:0] exp_q[$], ser_q[$];
  logic [7:0] held[16];
  int num_errors = 0, checked = 0, cycles = 0;
  initial forever #20 core_clk = ~core_clk;
  uafr_top #(.DEPTH(16)) u_dut (.core_clk, .rstn, .hsel, .haddr, .htrans,
    .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata,
    .hreadyout, .hresp, .serial_receive_pin(rx_line),
    .serial_transmit_pin(tx_line), .tx_dma_req, .rx_dma_req);
  uafr_remote #(.BIT(32)) u_remote (.core_clk, .line_in(tx_line),
    .line_out(rx_line), .nbits(nb), .got, .got_data);
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("Error at %0t: saw %h, expected %h", $time, g, e);
    end
  endtask
  task automatic test_done;
    $display("errors %0d, checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // One single transfer; both phases wait on ready, no fixed latency
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    @(posedge core_clk);
    while (hreadyout !== 1'b1) @(posedge core_clk);
    htrans <= 2'h0;
    hwdata <= d;
    dph <= !w;
    @(posedge core_clk);
    while (hreadyout !== 1'b1) @(posedge core_clk);
    dph <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask
  task automatic send(input logic [7:0] m);
    rnd = lfsr(rnd);
    ser_q.push_back({24'h0, rnd[7:0] & m});
    bus(1'b1, ADDR_DATA, rnd);
  endtask
  // Results are matched to the oldest note as they appear
  always @(posedge core_clk) begin
    if (dph && hreadyout) chk(hrdata, exp_q.pop_front());
    if (got) chk({24'h0, got_data}, ser_q.pop_front());
    cycles++;
    if (cycles == 40000) begin
      num_errors++;
      test_done();
    end
  end
  // Main sequence; the port is disabled around every divisor and line reconfiguration
  initial begin
    repeat (20) @(posedge core_clk);
    rstn <= 1'b1;
    @(posedge core_clk);
    rd(ADDR_CTRL, {22'h0, CTRL_RST});
    rd(ADDR_LVL, {26'h0, LVL_RST});
    rd(8'h28, 32'h0);
    bus(1'b1, ADDR_CTRL, 32'h300);
    bus(1'b1, ADDR_IDIV, 32'h2);
    bus(1'b1, ADDR_FDIV, 32'h0);
    for (int wl = 0; wl < 4; wl++) begin
      nb <= 4'h5 + wl[3:0];
      bus(1'b1, ADDR_LINE, {25'h0, wl[1:0], 5'h10});
      bus(1'b1, ADDR_CTRL, 32'h301);
      send(8'hff >> (3 - wl));
      while (ser_q.size() != 0) @(posedge core_clk);
      bus(1'b1, ADDR_CTRL, 32'h300);
    end
    bus(1'b1, ADDR_CTRL, 32'h301);
    for (int i = 0; i < 3; i++) send(8'hff);
    while (ser_q.size() != 0) @(posedge core_clk);
    rd(ADDR_FLAG, 32'h39);
    repeat (64) @(posedge core_clk);
    rd(ADDR_FLAG, 32'h29);
    bus(1'b1, ADDR_DMA, 32'h3);
    // Enable lands at the data phase end; the request follows a clock later
    repeat (2) @(posedge core_clk);
    chk({31'h0, tx_dma_req}, 32'h1);
    bus(1'b1, ADDR_CTRL, 32'h300);
    bus(1'b1, ADDR_IDIV, 32'h4);
    bus(1'b1, ADDR_CTRL, 32'h301);
    for (int i = 0; i < 17; i++) begin
      rnd = lfsr(rnd);
      if (i < 16) held[i] = rnd[7:0];
      u_remote.send_char(rnd[7:0], 1'b1);
    end
    chk({31'h0, rx_dma_req}, 32'h1);
    rd(ADDR_RXST, 32'h1);
    bus(1'b1, ADDR_RXST, 32'h0);
    rd(ADDR_RXST, 32'h0);
    for (int i = 0; i < 16; i++) rd(ADDR_DATA, {24'h0, held[i]});
    u_remote.send_char(8'h5a, 1'b0);
    // Overrun mark rides on the first character stored after the loss
    rd(ADDR_DATA, 32'h95a);
    u_remote.send_char(8'h00, 1'b0);
    rd(ADDR_DATA, 32'h500);
    bus(1'b1, ADDR_CTRL, 32'h300);
    bus(1'b1, ADDR_IDIV, 32'h2);
    // Break shorter than half a bit, so the far side drops it
    bus(1'b1, ADDR_LINE, 32'h57);
    repeat (8) @(posedge core_clk);
    chk({31'h0, tx_line}, 32'h0);
    // Seven data bits with even parity; the far side reads eight bits
    bus(1'b1, ADDR_LINE, 32'h56);
    bus(1'b1, ADDR_CTRL, 32'h301);
    u_remote.send_char(8'h01, 1'b1);
    rd(ADDR_DATA, 32'h201);
    rnd = lfsr(rnd);
    ser_q.push_back({24'h0, ^rnd[6:0], rnd[6:0]});
    bus(1'b1, ADDR_DATA, rnd);
    repeat (40) @(posedge core_clk);
    bus(1'b1, ADDR_CTRL, 32'h300);
    while (ser_q.size() != 0) @(posedge core_clk);
    test_done();
  end
endmodule
